// file: include/cse_pkg.sv
// Overview of operation
// - Delineation flag sets on either edge, if enabled
// - Other receive flags set on rising edge, if enabled
// - Reading flag register returns flags, then clears them
// - Flag bit order fixed; bit 4 reads zero
// - Transmit status clears on read, latches events
// - Bit 7 latches transmit input parity fault
// - Bit 6 latches transmit cell start fault
// - Bit 5 transmit overrun, bit 4 receive overrun
// - Bit 3 latches non-idle cell sent only
// - Transmit bits 2 to 0 read zero
// - Receive status bit 7 is live delineation level
// - Receive bits 6, 5 latch header errors
// - Bit 3 latches valid cell; bit 4 zero
// - Bit 2 latches idle header match
// - Bit 1 latches screening discard
// - Bit 0 latches nonzero flow control field
// - Idle tally counts idle cells; low, mid bytes
// - Reading idle tally low byte restarts count from zero
// - Tally is 19 bits; high byte bits 2 to 0
// - Enable register and outer enables gate interrupt
package cse_pkg;

	localparam int CSE_ADDR_W       = 8;
	localparam int CSE_DATA_W       = 8;
	localparam int CSE_IDLE_TALLY_W = 19;

	// Register offsets
	localparam logic [7:0] CSE_OFS_RX_IRQ_ENABLE = 8'h29;
	localparam logic [7:0] CSE_OFS_RX_IRQ_FLAGS  = 8'h2D;
	localparam logic [7:0] CSE_OFS_TX_STATUS     = 8'h2E;
	localparam logic [7:0] CSE_OFS_RX_STATUS     = 8'h2F;
	localparam logic [7:0] CSE_OFS_IDLE_LOW      = 8'h30;
	localparam logic [7:0] CSE_OFS_IDLE_MID      = 8'h31;
	localparam logic [7:0] CSE_OFS_IDLE_HIGH     = 8'h32;

	// Receive bit positions, shared by flags, enables and status
	localparam int CSE_BIT_DELIN    = 7;
	localparam int CSE_BIT_HDR_ERR  = 6;
	localparam int CSE_BIT_HDR_FIX  = 5;
	localparam int CSE_BIT_VALID    = 3;
	localparam int CSE_BIT_IDLE     = 2;
	localparam int CSE_BIT_SCREEN   = 1;
	localparam int CSE_BIT_FLOW     = 0;

	// Transmit bit positions
	localparam int CSE_BIT_TX_PARITY = 7;
	localparam int CSE_BIT_TX_START  = 6;
	localparam int CSE_BIT_TX_OVR    = 5;
	localparam int CSE_BIT_RX_OVR    = 4;
	localparam int CSE_BIT_TX_SENT   = 3;

	localparam logic [7:0] CSE_DELIN_MASK         = 8'h80;
	localparam logic [7:0] CSE_RX_EVENT_MASK      = 8'h6F;
	localparam logic [7:0] CSE_TX_RESERVED_MASK   = 8'h07;
	localparam logic [7:0] CSE_RX_IRQ_ENABLE_RST  = 8'hEF;
	localparam logic [7:0] CSE_RX_IRQ_ENABLE_WMSK = 8'hEF;
	localparam logic [7:0] CSE_ZERO_BYTE          = 8'h00;

	typedef struct packed {
		logic                  wr;    // Write strobe
		logic                  rd;    // Read strobe
		logic [CSE_ADDR_W-1:0] addr;  // Register offset
		logic [CSE_DATA_W-1:0] wdata; // Write data
	} cse_bus_req_type;

	typedef struct packed {
		logic header_error_uncorrected;
		logic header_error_fixed;
		logic valid_cell_arrived;
		logic idle_cell_arrived;
		logic screen_rejected;
		logic flow_field_nonzero;
	} cse_rx_event_type;

	typedef struct packed {
		logic tx_input_parity_fault;
		logic tx_cell_start_fault;
		logic tx_fifo_overrun;
		logic rx_fifo_overrun;
		logic user_cell_transmitted;
		logic tx_cell_is_idle;
	} cse_tx_event_type;

endpackage

// file: hw/cse_cell_status_regs.sv
`timescale 1ns/1ps
module cse_cell_status_regs
	import cse_pkg::*;
(
	input  wire logic            clk,                   // 25 MHz clock
	input  wire logic            rst,                   // Synchronous reset, high
	input  cse_bus_req_type      bus_req,               // Register request
	output logic [CSE_DATA_W-1:0] reg_rdata,            // Read data, cycle after read
	input  cse_rx_event_type     rx_events,             // Receive event pulses
	input  wire logic            delineation_lost,      // Live delineation level
	input  cse_tx_event_type     tx_events,             // Transmit event pulses
	input  wire logic            summary_rx_irq_enable, // Summary level enable
	input  wire logic            port_irq_enable,       // Port level enable
	output logic                 rx_irq_request         // Receive interrupt request
);

	// Map receive events onto the shared bit layout
	function automatic logic [CSE_DATA_W-1:0] cse_rx_vector(
		input cse_rx_event_type ev,
		input logic             delin
	);
		logic [CSE_DATA_W-1:0] v;
		v                  = CSE_ZERO_BYTE;
		v[CSE_BIT_DELIN]   = delin;
		v[CSE_BIT_HDR_ERR] = ev.header_error_uncorrected;
		v[CSE_BIT_HDR_FIX] = ev.header_error_fixed;
		v[CSE_BIT_VALID]   = ev.valid_cell_arrived;
		v[CSE_BIT_IDLE]    = ev.idle_cell_arrived;
		v[CSE_BIT_SCREEN]  = ev.screen_rejected;
		v[CSE_BIT_FLOW]    = ev.flow_field_nonzero;
		return v;
	endfunction

	// Map transmit events; idle cells never count as sent
	function automatic logic [CSE_DATA_W-1:0] cse_tx_vector(input cse_tx_event_type ev);
		logic [CSE_DATA_W-1:0] v;
		v                    = CSE_ZERO_BYTE;
		v[CSE_BIT_TX_PARITY] = ev.tx_input_parity_fault;
		v[CSE_BIT_TX_START]  = ev.tx_cell_start_fault;
		v[CSE_BIT_TX_OVR]    = ev.tx_fifo_overrun;
		v[CSE_BIT_RX_OVR]    = ev.rx_fifo_overrun;
		v[CSE_BIT_TX_SENT]   = ev.user_cell_transmitted & ~ev.tx_cell_is_idle;
		return v;
	endfunction

	logic [CSE_DATA_W-1:0]       irq_flags;
	logic [CSE_DATA_W-1:0]       irq_enable;
	logic [CSE_DATA_W-1:0]       rx_status;
	logic [CSE_DATA_W-1:0]       tx_status;
	logic [CSE_DATA_W-1:0]       rx_prev;
	logic [CSE_IDLE_TALLY_W-1:0] idle_tally;
	logic [CSE_IDLE_TALLY_W-CSE_DATA_W-1:0] idle_hold;

	logic [CSE_DATA_W-1:0]       rx_now;
	logic [CSE_DATA_W-1:0]       rx_edge;
	logic [CSE_DATA_W-1:0]       irq_set;
	logic [CSE_DATA_W-1:0]       tx_set;
	logic [CSE_DATA_W-1:0]       rx_live;
	logic                        idle_inc;
	logic                        rd_flags;
	logic                        rd_tx;
	logic                        rd_rx;
	logic                        rd_low;
	logic                        rd_mid;
	logic                        rd_high;
	logic                        rd_enable;
	logic                        wr_enable;

	logic [CSE_DATA_W-1:0]       next_irq_flags;
	logic [CSE_DATA_W-1:0]       next_irq_enable;
	logic [CSE_DATA_W-1:0]       next_rx_status;
	logic [CSE_DATA_W-1:0]       next_tx_status;
	logic [CSE_IDLE_TALLY_W-1:0] next_idle_tally;
	logic [CSE_IDLE_TALLY_W-CSE_DATA_W-1:0] next_idle_hold;
	logic [CSE_DATA_W-1:0]       next_rdata;
	logic                        next_irq_request;

	// Address strobes for each register
	assign rd_flags  = bus_req.rd && (bus_req.addr == CSE_OFS_RX_IRQ_FLAGS);
	assign rd_tx     = bus_req.rd && (bus_req.addr == CSE_OFS_TX_STATUS);
	assign rd_rx     = bus_req.rd && (bus_req.addr == CSE_OFS_RX_STATUS);
	assign rd_low    = bus_req.rd && (bus_req.addr == CSE_OFS_IDLE_LOW);
	assign rd_mid    = bus_req.rd && (bus_req.addr == CSE_OFS_IDLE_MID);
	assign rd_high   = bus_req.rd && (bus_req.addr == CSE_OFS_IDLE_HIGH);
	assign rd_enable = bus_req.rd && (bus_req.addr == CSE_OFS_RX_IRQ_ENABLE);
	assign wr_enable = bus_req.wr && (bus_req.addr == CSE_OFS_RX_IRQ_ENABLE);

	// Edge detection: delineation is dual edge, the rest rise only
	assign rx_now  = cse_rx_vector(rx_events, delineation_lost);
	assign rx_edge = ((rx_now & ~rx_prev) & ~CSE_DELIN_MASK)
		| ((rx_now ^ rx_prev) & CSE_DELIN_MASK);
	assign irq_set = rx_edge & irq_enable;

	// Sticky flags; a set in the clearing cycle survives the read
	assign next_irq_flags = (irq_flags & ~{CSE_DATA_W{rd_flags}}) | irq_set;

	// Receive status events; bit 7 is merged live at read time
	assign next_rx_status = (rx_status & ~{CSE_DATA_W{rd_rx}})
		| (rx_now & CSE_RX_EVENT_MASK);
	assign rx_live        = rx_status | (rx_now & CSE_DELIN_MASK);

	// Transmit status; reserved and factory bits never set
	assign tx_set         = cse_tx_vector(tx_events) & ~CSE_TX_RESERVED_MASK;
	assign next_tx_status = (tx_status & ~{CSE_DATA_W{rd_tx}}) | tx_set;

	// Idle tally: low byte read freezes upper bits and restarts the count
	assign idle_inc        = rx_events.idle_cell_arrived;
	assign next_idle_tally = rd_low ? CSE_IDLE_TALLY_W'(idle_inc)
		: idle_tally + CSE_IDLE_TALLY_W'(idle_inc);
	assign next_idle_hold  = rd_low ? idle_tally[CSE_IDLE_TALLY_W-1:CSE_DATA_W]
		: idle_hold;

	// Reserved enable bit is forced low on write
	assign next_irq_enable = wr_enable ? (bus_req.wdata & CSE_RX_IRQ_ENABLE_WMSK)
		: irq_enable;

	// Outer enables are held outside this block and only gate the request
	assign next_irq_request = (|irq_flags) & summary_rx_irq_enable & port_irq_enable;

	// Read data mux; unmapped offsets and idle cycles return zero
	always_comb begin
		if (rd_flags) begin
			next_rdata = irq_flags;
		end else if (rd_tx) begin
			next_rdata = tx_status;
		end else if (rd_rx) begin
			next_rdata = rx_live;
		end else if (rd_low) begin
			next_rdata = idle_tally[CSE_DATA_W-1:0];
		end else if (rd_mid) begin
			next_rdata = idle_hold[CSE_DATA_W-1:0];
		end else if (rd_high) begin
			next_rdata = CSE_DATA_W'(idle_hold[CSE_IDLE_TALLY_W-CSE_DATA_W-1:CSE_DATA_W]);
		end else if (rd_enable) begin
			next_rdata = irq_enable;
		end else begin
			next_rdata = CSE_ZERO_BYTE;
		end
	end

	// Previous receive levels; loaded in reset so a level held through reset
	// does not raise a false delineation flag at release
	always_ff @(posedge clk) begin
		rx_prev <= rx_now;
	end

	// Status and flag registers
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_flags  <= CSE_ZERO_BYTE;
			rx_status  <= CSE_ZERO_BYTE;
			tx_status  <= CSE_ZERO_BYTE;
			irq_enable <= CSE_RX_IRQ_ENABLE_RST;
		end else begin
			irq_flags  <= next_irq_flags;
			rx_status  <= next_rx_status;
			tx_status  <= next_tx_status;
			irq_enable <= next_irq_enable;
		end
	end

	// Idle tally and its snapshot
	always_ff @(posedge clk) begin
		if (rst) begin
			idle_tally <= '0;
			idle_hold  <= '0;
		end else begin
			idle_tally <= next_idle_tally;
			idle_hold  <= next_idle_hold;
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata      <= CSE_ZERO_BYTE;
			rx_irq_request <= 1'b0;
		end else begin
			reg_rdata      <= next_rdata;
			rx_irq_request <= next_irq_request;
		end
	end

	default clocking cse_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Delineation change with enable raises bit 7 next cycle
	delin_flag_a: assert property (
		((delineation_lost != $past(delineation_lost)) && irq_enable[CSE_BIT_DELIN])
		|=> irq_flags[CSE_BIT_DELIN])
		else $error("delineation flag not set on change");

	// No flag rises without a qualifying edge
	flag_cause_a: assert property (
		((irq_flags & ~$past(irq_flags) & ~$past(irq_set)) == CSE_ZERO_BYTE))
		else $error("interrupt flag rose without cause");

	// Masked idle event never sets its flag
	flag_masked_a: assert property (
		(!irq_enable[CSE_BIT_IDLE] && !irq_flags[CSE_BIT_IDLE])
		|=> !irq_flags[CSE_BIT_IDLE])
		else $error("masked idle flag was set");

	// Flag read returns flags and leaves them clear
	flag_read_a: assert property (
		(rd_flags && (irq_set == CSE_ZERO_BYTE))
		|=> (reg_rdata == $past(irq_flags)) && (irq_flags == CSE_ZERO_BYTE))
		else $error("flag read did not clear");

	// Reserved flag bit stays low
	flag_rsvd_a: assert property (
		(irq_flags & ~CSE_RX_IRQ_ENABLE_WMSK) == CSE_ZERO_BYTE)
		else $error("reserved flag bit set");

	// Transmit status clears on read
	tx_clear_a: assert property (
		(rd_tx && (tx_set == CSE_ZERO_BYTE))
		|=> (tx_status == CSE_ZERO_BYTE) && (reg_rdata == $past(tx_status)))
		else $error("transmit status not cleared by read");

	// Idle cell sent does not mark a sent cell
	tx_sent_a: assert property (
		$rose(tx_status[CSE_BIT_TX_SENT])
		|-> $past(tx_events.user_cell_transmitted && !tx_events.tx_cell_is_idle))
		else $error("sent bit set without user cell");

	// Reserved transmit bits stay low
	tx_rsvd_a: assert property (
		(tx_status & CSE_TX_RESERVED_MASK) == CSE_ZERO_BYTE)
		else $error("reserved transmit bit set");

	// Receive status bit 7 follows the live level
	rx_live_a: assert property (
		rd_rx |=> (reg_rdata[CSE_BIT_DELIN] == $past(delineation_lost)))
		else $error("live delineation bit wrong");

	// Tally counts idle cells between reads
	tally_count_a: assert property (
		(idle_inc && !rd_low)
		|=> idle_tally == CSE_IDLE_TALLY_W'($past(idle_tally) + 1'b1))
		else $error("idle tally did not count");

	// Low byte read restarts the tally and snapshots upper bits
	tally_clear_a: assert property (
		(rd_low && !idle_inc)
		|=> (idle_tally == '0) && (reg_rdata == $past(idle_tally[CSE_DATA_W-1:0]))
		&& (idle_hold == $past(idle_tally[CSE_IDLE_TALLY_W-1:CSE_DATA_W])))
		else $error("idle tally not restarted");

	// High byte read shows three snapshot bits below five zeros
	tally_high_a: assert property (
		rd_high |=> reg_rdata == CSE_DATA_W'($past(idle_hold) >> CSE_DATA_W))
		else $error("idle high byte wrong");

	// Interrupt request follows flags and outer enables
	irq_out_a: assert property (
		((irq_flags != CSE_ZERO_BYTE) && summary_rx_irq_enable && port_irq_enable)
		|=> rx_irq_request)
		else $error("interrupt request missing");

	// Enabled rising idle event raises its flag next cycle
	flag_rise_a: assert property (
		(rx_events.idle_cell_arrived && !$past(rx_events.idle_cell_arrived)
		&& irq_enable[CSE_BIT_IDLE]) |=> irq_flags[CSE_BIT_IDLE])
		else $error("idle flag not set on rising event");

	// Parity fault latches in transmit bit 7
	tx_parity_a: assert property (
		tx_events.tx_input_parity_fault |=> tx_status[CSE_BIT_TX_PARITY])
		else $error("parity fault not latched");

	// Cell start fault latches in transmit bit 6
	tx_start_a: assert property (
		tx_events.tx_cell_start_fault |=> tx_status[CSE_BIT_TX_START])
		else $error("cell start fault not latched");

	// Transmit overrun latches in bit 5
	tx_overrun_a: assert property (
		tx_events.tx_fifo_overrun |=> tx_status[CSE_BIT_TX_OVR])
		else $error("transmit overrun not latched");

	// Receive overrun latches in transmit register bit 4
	rx_overrun_a: assert property (
		tx_events.rx_fifo_overrun |=> tx_status[CSE_BIT_RX_OVR])
		else $error("receive overrun not latched");

	// A user cell sent marks bit 3
	sent_set_a: assert property (
		(tx_events.user_cell_transmitted && !tx_events.tx_cell_is_idle)
		|=> tx_status[CSE_BIT_TX_SENT])
		else $error("user cell sent not latched");

	// Latched transmit events stay until a read
	tx_hold_a: assert property (
		((tx_status != CSE_ZERO_BYTE) && !rd_tx)
		|=> (tx_status & $past(tx_status)) == $past(tx_status))
		else $error("transmit event lost without read");

	// Uncorrected header error latches in bit 6
	hdr_err_a: assert property (
		rx_events.header_error_uncorrected |=> rx_status[CSE_BIT_HDR_ERR])
		else $error("header error not latched");

	// Corrected header error latches in bit 5
	hdr_fix_a: assert property (
		rx_events.header_error_fixed |=> rx_status[CSE_BIT_HDR_FIX])
		else $error("header fix not latched");

	// Valid cell latches in bit 3
	rx_valid_a: assert property (
		rx_events.valid_cell_arrived |=> rx_status[CSE_BIT_VALID])
		else $error("valid cell not latched");

	// Idle header match latches in bit 2
	rx_idle_a: assert property (
		rx_events.idle_cell_arrived |=> rx_status[CSE_BIT_IDLE])
		else $error("idle cell not latched");

	// Screening discard latches in bit 1
	rx_screen_a: assert property (
		rx_events.screen_rejected |=> rx_status[CSE_BIT_SCREEN])
		else $error("screen discard not latched");

	// Nonzero flow field latches in bit 0
	rx_flow_a: assert property (
		rx_events.flow_field_nonzero |=> rx_status[CSE_BIT_FLOW])
		else $error("flow field event not latched");

	// Receive status read returns events and clears them
	rx_clear_a: assert property (
		(rd_rx && (rx_events == '0)) |=> (rx_status == CSE_ZERO_BYTE)
		&& (reg_rdata[CSE_BIT_DELIN-1:0] == $past(rx_status[CSE_BIT_DELIN-1:0])))
		else $error("receive status not cleared by read");

	// Stored receive status never holds bit 7 or bit 4
	rx_rsvd_a: assert property (
		(rx_status & ~CSE_RX_EVENT_MASK) == CSE_ZERO_BYTE)
		else $error("reserved receive bit set");

	// Mid byte read returns the snapshot
	mid_read_a: assert property (
		rd_mid |=> reg_rdata == $past(idle_hold[CSE_DATA_W-1:0]))
		else $error("idle mid byte wrong");

	// Snapshot changes only on a low byte read
	hold_keep_a: assert property (
		!rd_low |=> idle_hold == $past(idle_hold))
		else $error("idle snapshot changed without read");

	delin_irq_c: cover property (
		(delineation_lost != $past(delineation_lost)) ##1 irq_flags[CSE_BIT_DELIN]);
	set_on_read_c: cover property (rd_flags && (irq_set != CSE_ZERO_BYTE));
	tally_read_c: cover property (rd_low ##1 rd_mid ##1 rd_high);
	irq_out_c: cover property ($rose(rx_irq_request));
	tx_sent_c: cover property (tx_status[CSE_BIT_TX_SENT] ##1 rd_tx);

endmodule

// file: dv/cse_host_model.sv
`timescale 1ns/1ps
module cse_host_model
	import cse_pkg::*;
(
	input  wire logic       clk,       // Bus clock
	output cse_bus_req_type bus_req,   // Register request to the block
	input  wire logic [7:0] reg_rdata  // Read data, cycle after the read
);
	// Bus idles until a task launches a request
	initial bus_req = '0;

	// One-cycle write strobe, launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		bus_req <= '{1'b1, 1'b0, a, v};
		@(posedge clk);
		bus_req <= '0;
	endtask

	// Data is taken only once the answer cycle has settled, never at the edge itself
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		bus_req <= '0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb
	import cse_pkg::*;
;
	logic             clk;
	logic             rst;
	cse_bus_req_type  bus_req;
	logic [7:0]       reg_rdata;
	cse_rx_event_type rx_ev;
	cse_tx_event_type tx_ev;
	logic             delin;
	logic             sum_en;
	logic             port_en;
	logic             irq;
	logic [7:0]       got;
	int               mismatches;
	int               checks_done;
	int               cycles;
	int               i;
	logic [7:0]       zero_ofs [7] = '{8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h40};
	logic [7:0]       rx_map [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	cse_cell_status_regs DUT (
		.clk                   (clk),
		.rst                   (rst),
		.bus_req               (bus_req),
		.reg_rdata             (reg_rdata),
		.rx_events             (rx_ev),
		.delineation_lost      (delin),
		.tx_events             (tx_ev),
		.summary_rx_irq_enable (sum_en),
		.port_irq_enable       (port_en),
		.rx_irq_request        (irq)
	);

	cse_host_model u_host (
		.clk       (clk),
		.bus_req   (bus_req),
		.reg_rdata (reg_rdata)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] want);
		u_host.rd(a, got);
		chk(got, want);
	endtask

	// Events are single-cycle pulses from the datapath
	task automatic rxp(input cse_rx_event_type v);
		@(posedge clk);
		rx_ev <= v;
		@(posedge clk);
		rx_ev <= '0;
	endtask

	task automatic txp(input cse_tx_event_type v);
		@(posedge clk);
		tx_ev <= v;
		@(posedge clk);
		tx_ev <= '0;
	endtask

	task automatic irq_chk(input logic want);
		@(posedge clk);
		#1;
		chk({7'h00, irq}, {7'h00, want});
	endtask

	task automatic wrap_up();
		$display("mismatches %0d, checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		rst = 1'b1;
		rx_ev = '0;
		tx_ev = '0;
		delin = 1'b0;
		sum_en = 1'b1;
		port_en = 1'b1;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Reset contents, unmapped offset reads zero
		rc(8'h29, 8'hEF);
		foreach (zero_ofs[k]) rc(zero_ofs[k], 8'h00);
		irq_chk(1'b0);
		// Each receive event alone: flag, status, request, then clear on read
		for (i = 0; i < 6; i++) begin
			rxp(cse_rx_event_type'(6'h01 << i));
			irq_chk(1'b1);
			rc(8'h2D, rx_map[i]);
			rc(8'h2F, rx_map[i]);
			rc(8'h2D, 8'h00);
			rc(8'h2F, 8'h00);
			irq_chk(1'b0);
		end
		// Idle level held 300 cycles: tally 1 + 300, past the low byte
		@(posedge clk);
		rx_ev <= cse_rx_event_type'(6'h04);
		repeat (300) @(posedge clk);
		rx_ev <= '0;
		rc(8'h30, 8'h2D);
		rxp(cse_rx_event_type'(6'h04));
		rc(8'h31, 8'h01);
		rc(8'h32, 8'h00);
		rc(8'h30, 8'h01);
		rc(8'h2D, 8'h04);
		rc(8'h2F, 8'h04);
		// Event in the same cycle as the flag read survives the read
		fork
			u_host.rd(8'h2D, got);
			rxp(cse_rx_event_type'(6'h04));
		join
		chk(got, 8'h00);
		rc(8'h2D, 8'h04);
		rc(8'h2F, 8'h04);
		rc(8'h30, 8'h01);
		// Masked flag is lost but status still latches
		u_host.wr(8'h29, 8'hFF);
		rc(8'h29, 8'hEF);
		u_host.wr(8'h29, 8'h00);
		rxp(cse_rx_event_type'(6'h20));
		rc(8'h2D, 8'h00);
		rc(8'h2F, 8'h40);
		u_host.wr(8'h29, 8'hEF);
		// Delineation: live status, flag on both edges
		@(posedge clk);
		delin <= 1'b1;
		rc(8'h2F, 8'h80);
		rc(8'h2F, 8'h80);
		rc(8'h2D, 8'h80);
		@(posedge clk);
		delin <= 1'b0;
		rc(8'h2F, 8'h00);
		rc(8'h2D, 8'h80);
		// Outer enables gate the request line
		@(posedge clk);
		sum_en <= 1'b0;
		rxp(cse_rx_event_type'(6'h08));
		irq_chk(1'b0);
		@(posedge clk);
		sum_en <= 1'b1;
		irq_chk(1'b1);
		@(posedge clk);
		port_en <= 1'b0;
		irq_chk(1'b0);
		@(posedge clk);
		port_en <= 1'b1;
		rc(8'h2D, 8'h08);
		rc(8'h2F, 8'h08);
		// Transmit events one at a time; idle cells sent leave no mark
		for (i = 1; i < 6; i++) begin
			txp(cse_tx_event_type'(6'h01 << i));
			rc(8'h2E, 8'h04 << i);
			rc(8'h2E, 8'h00);
		end
		txp(cse_tx_event_type'(6'h03));
		rc(8'h2E, 8'h00);
		wrap_up();
	end
endmodule
